// *** common/spc_pkg.sv ***
// spc_pkg: constants and types of the scan port connect control.
// assumes the user pulls the connect logic in via spc_pkg::*.
package spc_pkg;

  // address field and the three global codes
  localparam int ADDR_W = 10;
  localparam logic [9:0] RESET_ADDR = 10'h000;
  localparam logic [9:0] DROP_ALL_CODE = 10'h3FE;
  localparam logic [9:0] SYNC_BROADCAST_CODE = 10'h3FF;

  // data pair counter, saturates for long addresses
  localparam logic [3:0] CNT_ADDR = 4'hA;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // acknowledge stream: I S D x10 S I, first bit at index 0
  localparam int ACK_BITS = 28;
  localparam int ACK_DATA_LSB = 4;
  localparam int ACK_TAIL_LSB = 24;
  localparam logic [3:0] ACK_HEAD = 4'h3;
  localparam logic [3:0] ACK_TAIL = 4'hC;
  localparam logic [4:0] ACK_LAST = 5'h1B;
  localparam logic [4:0] ACK_FIRST = 5'h00;
  localparam logic [4:0] ACK_STEP = 5'h01;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
    TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR,
    TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR,
    TAP_EXIT2_IR, TAP_UPD_IR
  } spc_tap_t;

  typedef enum logic [1:0] {
    CONN_RESET, CONN_OFF, CONN_ON, CONN_MULTICAST
  } spc_conn_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_SEL2, RX_D1, RX_D2, RX_END1, RX_END2
  } spc_rx_t;

  // standard test access port state step
  function automatic spc_tap_t spc_tap_next(spc_tap_t s, logic tms);
    case (s)
      TAP_RESET: spc_tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: spc_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: spc_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: spc_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: spc_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: spc_tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: spc_tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: spc_tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: spc_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: spc_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: spc_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: spc_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: spc_tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: spc_tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: spc_tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: spc_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: spc_tap_next = TAP_RESET;
    endcase
  endfunction : spc_tap_next

endpackage : spc_pkg

// *** core/spc_connect_control.sv ***
// spc_connect_control: connect control of a multidrop scan port switch.
// assumes a test master on the primary port and a scan chain behind
// the secondary port; the serial paths stay combinational switches.
module spc_connect_control
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic primary_test_clock,
  input wire logic primary_test_reset_n,
  input wire logic primary_serial_in,
  input wire logic primary_mode_select,
  input wire logic secondary_serial_in,
  input wire logic force_through_n,
  input wire logic [9:0] board_id_inputs,
  output logic primary_serial_out,
  output logic primary_serial_out_oe_n,
  output logic secondary_serial_out,
  output logic secondary_serial_out_oe_n,
  output logic secondary_mode_select,
  output logic link_active_n,
  output logic connected_sync
);

  spc_tap_t prim_tap, sec_tap, rx_start_tap, next_sec_tap;
  spc_rx_t rx_state, next_rx_state;
  spc_conn_t conn, next_conn;
  logic [9:0] rx_addr, next_rx_addr, ack_addr, id_meta, id_sync;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic rx_first, rx_ones, rx_zeros, next_ones, next_zeros;
  logic rx_fail, rx_done, ack_busy, next_ack_busy, mode_hold;
  logic [4:0] ack_cnt, next_ack_cnt;
  logic con_flag, con_meta;
  logic [ACK_BITS-1:0] ack_vec;

  // decode of tap states and control terms
  wire bypass = !force_through_n;
  wire rx_rst_n = primary_test_reset_n & force_through_n;
  wire prim_paused = (prim_tap == TAP_PAUSE_DR) || (prim_tap == TAP_PAUSE_IR);
  wire sec_paused = (sec_tap == TAP_PAUSE_DR) || (sec_tap == TAP_PAUSE_IR);
  wire prim_stable = prim_paused || (prim_tap == TAP_RESET)
    || (prim_tap == TAP_IDLE);
  wire rx_abort = (rx_state != RX_IDLE)
    && (!prim_stable || (prim_tap != rx_start_tap));
  wire conn_link = (conn == CONN_ON) || (conn == CONN_MULTICAST);

  // frame checks: exact length, or long all-ones / all-zeros
  wire len_ok = (rx_cnt == CNT_ADDR)
    || ((rx_cnt > CNT_ADDR) && (rx_ones || rx_zeros));
  wire frame_ok = rx_done && len_ok;
  wire hard_err = (rx_fail && (rx_cnt != CNT_ZERO))
    || (rx_done && !len_ok);
  wire hit_reset = rx_addr == RESET_ADDR;
  wire hit_drop = rx_addr == DROP_ALL_CODE;
  wire hit_sync = rx_addr == SYNC_BROADCAST_CODE;
  wire hit_match = rx_addr == id_sync;
  wire sync_ok = prim_paused && sec_paused;

  // acknowledge bit stream, data pairs low-high for one
  assign ack_vec[ACK_DATA_LSB-1:0] = ACK_HEAD;
  assign ack_vec[ACK_BITS-1:ACK_TAIL_LSB] = ACK_TAIL;
  genvar gi;
  generate
    for (gi = 0; gi < ADDR_W; gi++) begin : g_ack
      assign ack_vec[ACK_DATA_LSB + 2 * gi] = !ack_addr[gi];
      assign ack_vec[ACK_DATA_LSB + 2 * gi + 1] = ack_addr[gi];
    end
  endgenerate
  wire ack_bit = ack_vec[ack_cnt];

  // pin switch network, combinational so no retiming is inserted
  assign secondary_serial_out = primary_serial_in;
  assign secondary_serial_out_oe_n = !(bypass || conn_link);
  assign primary_serial_out = ack_busy ? ack_bit : secondary_serial_in;
  assign primary_serial_out_oe_n =
    !(bypass || (conn == CONN_ON) || ack_busy);
  assign secondary_mode_select = !primary_test_reset_n ? 1'h1
    : (bypass || conn_link) ? primary_mode_select
    : (conn == CONN_RESET) ? 1'h1
    : mode_hold;
  assign link_active_n = !(bypass || conn_link);

  // board id straps into the test clock domain
  always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
    if (!primary_test_reset_n) begin
      id_meta <= RESET_ADDR;
      id_sync <= RESET_ADDR;
    end else begin
      id_meta <= board_id_inputs;
      id_sync <= id_meta;
    end
  end

  // primary tap monitor and held mode select level
  always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
    if (!primary_test_reset_n) begin
      prim_tap <= TAP_RESET;
      sec_tap <= TAP_RESET;
      mode_hold <= 1'h1;
    end else begin
      prim_tap <= spc_tap_next(prim_tap, primary_mode_select);
      sec_tap <= next_sec_tap;
      mode_hold <= secondary_mode_select;
    end
  end

  // secondary tap tracking
  always_comb begin
    next_sec_tap = sec_tap;
    if (bypass || conn_link)
      next_sec_tap = spc_tap_next(sec_tap, primary_mode_select);
    else if (conn == CONN_RESET)
      next_sec_tap = spc_tap_next(sec_tap, 1'h1);
  end

  // select protocol receiver, one bit per rising test clock edge
  always_comb begin
    next_rx_state = rx_state;
    next_rx_addr = rx_addr;
    next_rx_cnt = rx_cnt;
    next_ones = rx_ones;
    next_zeros = rx_zeros;
    rx_fail = 1'h0;
    rx_done = 1'h0;
    if (rx_abort) begin
      next_rx_state = RX_IDLE;
      rx_fail = 1'h1;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (prim_stable && !primary_serial_in) begin
            next_rx_state = RX_SEL2;
            next_rx_cnt = CNT_ZERO;
            next_ones = 1'h1;
            next_zeros = 1'h1;
          end
        end
        RX_SEL2: next_rx_state = primary_serial_in ? RX_IDLE : RX_D1;
        RX_D1: next_rx_state = RX_D2;
        RX_D2: begin
          if (rx_first != primary_serial_in) begin
            next_rx_addr = {primary_serial_in, rx_addr[9:1]};
            if (rx_cnt != CNT_MAX)
              next_rx_cnt = rx_cnt + CNT_ONE;
            next_ones = rx_ones & primary_serial_in;
            next_zeros = rx_zeros & !primary_serial_in;
            next_rx_state = RX_D1;
          end else if (!primary_serial_in) begin
            next_rx_state = RX_END1;
          end else begin
            next_rx_state = RX_IDLE;
            rx_fail = 1'h1;
          end
        end
        RX_END1: begin
          next_rx_state = primary_serial_in ? RX_END2 : RX_IDLE;
          rx_fail = !primary_serial_in;
        end
        RX_END2: begin
          next_rx_state = RX_IDLE;
          rx_done = primary_serial_in;
          rx_fail = !primary_serial_in;
        end
        default: next_rx_state = RX_IDLE;
      endcase
    end
  end

  // receiver registers, forced to power-up state by reset or bypass
  always_ff @(posedge primary_test_clock or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rx_state <= RX_IDLE;
      rx_addr <= RESET_ADDR;
      rx_cnt <= CNT_ZERO;
      rx_first <= 1'h1;
      rx_ones <= 1'h0;
      rx_zeros <= 1'h0;
      rx_start_tap <= TAP_RESET;
    end else begin
      rx_state <= next_rx_state;
      rx_addr <= next_rx_addr;
      rx_cnt <= next_rx_cnt;
      rx_first <= primary_serial_in;
      rx_ones <= next_ones;
      rx_zeros <= next_zeros;
      if (rx_state == RX_IDLE)
        rx_start_tap <= prim_tap;
    end
  end

  // connect status from the last valid frame or hard error
  always_comb begin
    next_conn = conn;
    next_ack_busy = ack_busy;
    next_ack_cnt = ack_cnt;
    if (frame_ok) begin
      next_ack_busy = 1'h0;
      if (hit_reset)
        next_conn = CONN_RESET;
      else if (hit_drop)
        next_conn = CONN_OFF;
      else if (hit_sync)
        next_conn = sync_ok ? CONN_MULTICAST : CONN_OFF;
      else begin
        next_conn = CONN_OFF;
        next_ack_busy = hit_match;
        next_ack_cnt = ACK_FIRST;
      end
    end else if (hard_err) begin
      next_conn = CONN_OFF;
      next_ack_busy = 1'h0;
    end else if (ack_busy) begin
      if (ack_cnt == ACK_LAST) begin
        next_ack_busy = 1'h0;
        next_conn = CONN_ON;
      end else
        next_ack_cnt = ack_cnt + ACK_STEP;
    end
  end

  // status registers, held through bypass so release restores them
  always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
    if (!primary_test_reset_n) begin
      conn <= CONN_RESET;
      ack_busy <= 1'h0;
      ack_cnt <= ACK_FIRST;
      ack_addr <= RESET_ADDR;
      con_flag <= 1'h0;
    end else begin
      conn <= next_conn;
      ack_busy <= next_ack_busy;
      ack_cnt <= next_ack_cnt;
      if (frame_ok)
        ack_addr <= rx_addr;
      con_flag <= (next_conn == CONN_ON) || (next_conn == CONN_MULTICAST);
    end
  end

  // connection level into the system clock domain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      con_meta <= 1'h0;
      connected_sync <= 1'h0;
    end else begin
      con_meta <= con_flag;
      connected_sync <= con_meta;
    end
  end

  // checks on the test clock domain
  a_busy_states_ignored: assert property (
    @(posedge primary_test_clock) disable iff (!rx_rst_n)
    !prim_stable |=> rx_state == RX_IDLE && !rx_done)
    else $error("receiver active in a non-stable tap state");
  a_reset_code_result: assert property (
    @(posedge primary_test_clock) disable iff (!rx_rst_n)
    frame_ok && hit_reset |=> conn == CONN_RESET && !ack_busy)
    else $error("reset code did not give reset status");
  a_drop_all_off: assert property (
    @(posedge primary_test_clock) disable iff (!rx_rst_n)
    frame_ok && hit_drop |=> conn == CONN_OFF && !ack_busy)
    else $error("drop-all code did not give off status");
  a_sync_needs_pause: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    $rose(conn == CONN_MULTICAST) |-> $past(sync_ok) && $past(frame_ok))
    else $error("multicast entered without both ports paused");
  a_on_after_ack: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    $rose(conn == CONN_ON) |-> $past(ack_busy) && $past(ack_cnt) == ACK_LAST)
    else $error("on status reached without a full acknowledge");
  a_match_starts_ack: assert property (
    @(posedge primary_test_clock) disable iff (!rx_rst_n)
    frame_ok && hit_match && !hit_reset && !hit_drop && !hit_sync
    |=> ack_busy && ack_cnt == ACK_FIRST && primary_serial_out
    ##1 ack_busy && ack_cnt == ACK_STEP && primary_serial_out)
    else $error("match did not start the acknowledge stream");
  a_on_routing: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    conn == CONN_ON && force_through_n |-> !primary_serial_out_oe_n
    && primary_serial_out == secondary_serial_in && !secondary_serial_out_oe_n)
    else $error("on status does not route the serial paths");
  a_off_floats: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    conn == CONN_OFF && force_through_n && !ack_busy
    |-> primary_serial_out_oe_n && secondary_serial_out_oe_n)
    else $error("off status drives a serial output");
  a_bypass_links: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    !force_through_n |-> !link_active_n && !secondary_serial_out_oe_n
    && secondary_mode_select == primary_mode_select && rx_state == RX_IDLE)
    else $error("bypass does not connect the ports");
  a_ack_indicator: assert property (
    @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
    ack_busy && force_through_n |-> link_active_n)
    else $error("indicator low during acknowledge");
  c_match_on: cover property (@(posedge primary_test_clock)
    $rose(conn == CONN_ON));
  c_multicast: cover property (@(posedge primary_test_clock)
    $rose(conn == CONN_MULTICAST));
  c_reset_code: cover property (@(posedge primary_test_clock)
    frame_ok && hit_reset);
  c_hard_error: cover property (@(posedge primary_test_clock)
    hard_err && conn == CONN_ON);

endmodule : spc_connect_control

// *** test/spc_master_model.sv ***
// spc_master_model: backplane test master on the primary test port.
// assumes the bench calls its tasks; the test clock only runs in them.
module spc_master_model (
  output logic primary_test_clock,
  output logic primary_mode_select,
  output logic primary_serial_in,
  output logic primary_test_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle lines: clock parked low, data high as its pull-up leaves it
  initial begin
    primary_test_clock = 1'b0;
    primary_mode_select = 1'b0;
    primary_serial_in = 1'b1;
    primary_test_reset_n = 1'b0;
  end

  // move the lines with the clock parked
  task automatic set(input logic tms, input logic tdi);
    primary_mode_select = tms;
    primary_serial_in = tdi;
  endtask : set

  // test reset level
  task automatic treset(input logic v);
    primary_test_reset_n = v;
  endtask : treset

  // one test clock period, lines set at the falling edge
  task automatic step(input logic tms, input logic tdi);
    set(tms, tdi);
    #7.5 primary_test_clock = 1'b1;
    #7.5 primary_test_clock = 1'b0;
  endtask : step

  // select frame: S, n data pairs lsb first, S, I; state held
  task automatic frame(input logic [9:0] addr, input int n);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      step(1'b0, ~addr[k]);
      step(1'b0, addr[k]);
    end
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
  endtask : frame
endmodule : spc_master_model

// *** test/tb_scan_port_connect_control.sv ***
// tb_scan_port_connect_control: self-checking bench of the connect control.
// assumes spc_pkg is compiled first; the master model drives the port.
module tb_scan_port_connect_control
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic primary_test_clock, primary_test_reset_n;
  logic primary_serial_in, primary_mode_select;
  logic secondary_serial_in = 1'b1;
  logic force_through_n = 1'b1;
  logic [9:0] board_id_inputs = 10'h000;
  logic primary_serial_out, primary_serial_out_oe_n;
  logic secondary_serial_out, secondary_serial_out_oe_n;
  logic secondary_mode_select, link_active_n, connected_sync;
  logic [13:0] exp_q[$];
  logic [6:0] obs;
  logic [9:0] id;
  int failures = 0;
  int checked = 0;
  event look;

  // system clock, 5 ns
  always #2.5 clk = ~clk;

  spc_master_model master (
    .primary_test_clock(primary_test_clock),
    .primary_mode_select(primary_mode_select),
    .primary_serial_in(primary_serial_in),
    .primary_test_reset_n(primary_test_reset_n)
  );

  spc_connect_control uut (
    .clk(clk),
    .rstn(rstn),
    .primary_test_clock(primary_test_clock),
    .primary_test_reset_n(primary_test_reset_n),
    .primary_serial_in(primary_serial_in),
    .primary_mode_select(primary_mode_select),
    .secondary_serial_in(secondary_serial_in),
    .force_through_n(force_through_n),
    .board_id_inputs(board_id_inputs),
    .primary_serial_out(primary_serial_out),
    .primary_serial_out_oe_n(primary_serial_out_oe_n),
    .secondary_serial_out(secondary_serial_out),
    .secondary_serial_out_oe_n(secondary_serial_out_oe_n),
    .secondary_mode_select(secondary_mode_select),
    .link_active_n(link_active_n),
    .connected_sync(connected_sync)
  );

  // observed vector: sync, oe pri, oe sec, link, mode, pri out, sec out
  assign obs = {connected_sync, primary_serial_out_oe_n,
    secondary_serial_out_oe_n, link_active_n, secondary_mode_select,
    primary_serial_out, secondary_serial_out};

  // monitor: oldest note against the settled outputs
  always @(look) begin
    logic [13:0] e;
    e = exp_q.pop_front();
    checked++;
    if (((obs ^ e[6:0]) & e[13:7]) !== 7'h00) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e[6:0], obs);
    end
  end

  // verdict and end of run
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // expectation note {mask, value}, then the monitor looks
  task automatic note(input logic [6:0] m, input logic [6:0] v);
    exp_q.push_back({m, v});
    #0.1 -> look;
    #0.1;
  endtask : note

  // note after the sync crossing has settled
  task automatic hold_chk(input logic [6:0] m, input logic [6:0] v);
    #20 note(m, v);
  endtask : hold_chk

  // through paths, lines moved with the test clock parked
  task automatic route(input logic [6:0] base, input logic [6:0] m);
    logic [2:0] r;
    for (int k = 0; k < 3; k++) begin
      r = 3'($urandom);
      @(negedge clk);
      secondary_serial_in = r[1];
      master.set(r[2], r[0]);
      hold_chk(m, base | {4'h0, r});
    end
    master.set(1'b0, 1'b1);
  endtask : route

  // acknowledge stream, one bit per test clock, then on status
  task automatic link_up(input logic [9:0] a);
    logic b;
    master.frame(a, 10);
    for (int k = 0; k < 28; k++) begin
      if (k < 2 || k > 25) b = 1'b1;
      else if (k < 4 || k > 23) b = 1'b0;
      else b = a[(k - 4) / 2] ^ ((k % 2) == 0);
      note(7'h2A, {4'h1, 1'b0, b, 1'b0});
      master.step(1'b0, 1'b1);
    end
    route(7'h40, 7'h7F);
  endtask : link_up

  // hang guard
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(32'hD5B4));
    id = 10'h001 + 10'($urandom % 1020);
    board_id_inputs = id;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    master.treset(1'b1);
    hold_chk(7'h7C, 7'h3C);
    repeat (3) master.step(1'b0, 1'b1);
    link_up(id);
    // realign both taps through test-logic-reset first
    repeat (3) master.step(1'b1, 1'b1);
    master.step(1'b0, 1'b1);
    // into shift-ir, where frames are ignored
    master.step(1'b1, 1'b1);
    master.step(1'b1, 1'b1);
    master.step(1'b0, 1'b1);
    master.step(1'b0, 1'b1);
    master.frame(id + 10'h001, 10);
    hold_chk(7'h7D, 7'h41);
    master.step(1'b1, 1'b1);
    master.step(1'b0, 1'b1);
    master.frame(SYNC_BROADCAST_CODE, 10);
    route(7'h60, 7'h7D);
    master.frame(DROP_ALL_CODE, 10);
    note(7'h3C, 7'h38);
    // bypass over off status
    @(negedge clk) force_through_n = 1'b0;
    route(7'h00, 7'h3F);
    master.frame(id, 10);
    @(negedge clk) force_through_n = 1'b1;
    hold_chk(7'h7C, 7'h38);
    master.step(1'b1, 1'b1);
    master.step(1'b1, 1'b1);
    master.step(1'b0, 1'b1);
    master.frame(SYNC_BROADCAST_CODE, 10);
    hold_chk(7'h7C, 7'h38);
    link_up(id);
    master.frame(id + 10'h001, 10);
    note(7'h3C, 7'h38);
    link_up(id);
    master.frame(id, 5);
    note(7'h3C, 7'h38);
    master.frame(RESET_ADDR, 10);
    note(7'h3C, 7'h3C);
    // bypass with the test reset low
    @(negedge clk) force_through_n = 1'b0;
    master.treset(1'b0);
    hold_chk(7'h3D, 7'h05);
    master.treset(1'b1);
    @(negedge clk) force_through_n = 1'b1;
    hold_chk(7'h7C, 7'h3C);
    finish_test();
  end
endmodule : tb_scan_port_connect_control
